/* File: design/buffer_write_page_program.sv */
`timescale 1ns/10ps
// ==========================================================
// Buffer load and buffer-to-page program sequencer
module buffer_write_page_program #(
    parameter logic [15:0] ERASE_CYCLES   = flash_seq_pkg::ERASE_CYCLES,
    parameter logic [15:0] PROGRAM_CYCLES = flash_seq_pkg::PROGRAM_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      spi_cs_n,
    input  wire logic                      spi_sck,
    input  wire logic                      spi_si,
    input  wire logic                      page_size_256,
    input  wire logic                      array_fail,
    output flash_seq_pkg::array_req_s      array_req,
    output logic                           status_busy,
    output logic                           erase_program_error_flag
);

    // ==========================================================
    // Link side and crossings
    logic [7:0] rx_byte;
    logic       rx_toggle;

    spi_byte_rx u_rx (
        .spi_sck   (spi_sck),
        .spi_cs_n  (spi_cs_n),
        .spi_si    (spi_si),
        .sys_rst   (sys_rst),
        .rx_byte   (rx_byte),
        .rx_toggle (rx_toggle)
    );

    logic [2:0] cs_sync;
    logic [2:0] tg_sync;
    logic       cs_lvl;
    logic       tg_lvl;
    logic [2:0] next_cs_sync;
    logic [2:0] next_tg_sync;
    logic       next_cs_lvl;
    logic       next_tg_lvl;
    logic       cs_change;
    logic       cs_fall;
    logic       cs_rise;
    logic       byte_ev;

    // A change counts only once the second and third stages agree.
    always_comb begin
        next_cs_sync = {cs_sync[1:0], spi_cs_n};
        next_tg_sync = {tg_sync[1:0], rx_toggle};
        cs_change    = (cs_sync[1] == cs_sync[2]) && (cs_sync[2] != cs_lvl);
        byte_ev      = (tg_sync[1] == tg_sync[2]) && (tg_sync[2] != tg_lvl);
        cs_fall      = cs_change && !cs_sync[2];
        cs_rise      = cs_change && cs_sync[2];
        next_cs_lvl  = cs_change ? cs_sync[2] : cs_lvl;
        next_tg_lvl  = byte_ev ? tg_sync[2] : tg_lvl;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cs_sync <= 3'h7;
            tg_sync <= 3'h0;
            cs_lvl  <= 1'b1;
            tg_lvl  <= 1'b0;
        end else begin
            cs_sync <= next_cs_sync;
            tg_sync <= next_tg_sync;
            cs_lvl  <= next_cs_lvl;
            tg_lvl  <= next_tg_lvl;
        end
    end

    // ==========================================================
    // Page buffers
    logic [7:0] buf_mem [0:1][0:flash_seq_pkg::BUF_DEPTH-1];
    logic       buf_we;
    logic       buf_wsel;
    logic [8:0] buf_wptr;

    // The sequencer only ever reads the buffers, so a program keeps their data.
    always_ff @(posedge clk) begin
        if (buf_we) begin
            buf_mem[buf_wsel][buf_wptr] <= rx_byte;
        end
    end

    // ==========================================================
    // Command decode and sequencer
    flash_seq_pkg::cmd_s       cmd;
    flash_seq_pkg::cmd_s       next_cmd;
    flash_seq_pkg::seq_state_e state;
    flash_seq_pkg::seq_state_e next_state;
    flash_seq_pkg::array_req_s next_array_req;
    logic                      in_frame;
    logic                      next_in_frame;
    logic [2:0]                byte_cnt;
    logic [2:0]                next_byte_cnt;
    logic [15:0]               addr;
    logic [15:0]               next_addr;
    logic [8:0]                ptr;
    logic [8:0]                next_ptr;
    logic                      op_sel;
    logic                      next_op_sel;
    logic                      op_erase;
    logic                      next_op_erase;
    logic [14:0]               op_page;
    logic [14:0]               next_op_page;
    logic [8:0]                op_idx;
    logic [8:0]                next_op_idx;
    logic [15:0]               op_cnt;
    logic [15:0]               next_op_cnt;
    logic                      next_busy;
    logic                      next_err;
    logic                      op_start;
    logic [8:0]                last_loc;
    logic [23:0]               full_addr;
    flash_seq_pkg::cmd_s       dec;

    always_comb begin
        next_in_frame  = in_frame;
        next_byte_cnt  = byte_cnt;
        next_addr      = addr;
        next_ptr       = ptr;
        next_cmd       = cmd;
        next_state     = state;
        next_op_sel    = op_sel;
        next_op_erase  = op_erase;
        next_op_page   = op_page;
        next_op_idx    = op_idx;
        next_op_cnt    = op_cnt;
        next_array_req = '0;
        next_err       = erase_program_error_flag;
        buf_we         = 1'b0;
        buf_wsel       = cmd.sel;
        buf_wptr       = ptr;
        op_start       = 1'b0;
        last_loc       = page_size_256 ? flash_seq_pkg::LAST_BIN : flash_seq_pkg::LAST_STD;
        full_addr      = {addr, rx_byte};
        dec            = flash_seq_pkg::decode_op(rx_byte);

        // Select falling opens a frame and clears the byte count.
        if (cs_fall) begin
            next_in_frame = 1'b1;
            next_byte_cnt = 3'h0;
            next_cmd      = '{flash_seq_pkg::CMD_NONE, 1'b0};
        end

        // Byte 0 is the opcode, bytes 1 to 3 the address, then data.
        if (byte_ev && in_frame) begin
            if (byte_cnt == 3'h0) begin
                next_cmd = dec;
                // A load into the buffer under program would corrupt it.
                if (dec.kind == flash_seq_pkg::CMD_LOAD && state != flash_seq_pkg::ST_IDLE
                    && dec.sel == op_sel) begin
                    next_cmd.kind = flash_seq_pkg::CMD_NONE;
                end
                if (dec.kind == flash_seq_pkg::CMD_LOAD_PROG
                    && state != flash_seq_pkg::ST_IDLE) begin
                    next_cmd.kind = flash_seq_pkg::CMD_NONE;
                end
            end else if (byte_cnt <= flash_seq_pkg::LAST_ADDR) begin
                if (byte_cnt == flash_seq_pkg::LAST_ADDR) begin
                    // Start location: low 9 bits, or low 8 bits for 256-byte pages.
                    next_ptr = page_size_256 ? {1'b0, full_addr[7:0]} : full_addr[8:0];
                end else begin
                    // Only the upper two address bytes are kept, since the page lies there.
                    next_addr = {addr[7:0], rx_byte};
                end
            end else if (cmd.kind == flash_seq_pkg::CMD_LOAD
                         || cmd.kind == flash_seq_pkg::CMD_LOAD_PROG) begin
                buf_we   = 1'b1;
                next_ptr = (ptr == last_loc) ? 9'h000 : ptr + 9'h001;
            end
            if (byte_cnt != flash_seq_pkg::DATA_IDX) begin
                next_byte_cnt = byte_cnt + 3'h1;
            end
        end

        // Select rising ends the frame; a full address launches a program.
        if (cs_rise && in_frame) begin
            next_in_frame = 1'b0;
            if (next_byte_cnt == flash_seq_pkg::DATA_IDX && state == flash_seq_pkg::ST_IDLE
                && (next_cmd.kind == flash_seq_pkg::CMD_PROG_ERASE
                    || next_cmd.kind == flash_seq_pkg::CMD_PROG_PLAIN
                    || next_cmd.kind == flash_seq_pkg::CMD_LOAD_PROG)) begin
                op_start      = 1'b1;
                next_op_sel   = next_cmd.sel;
                next_op_erase = next_cmd.kind != flash_seq_pkg::CMD_PROG_PLAIN;
                // Page field: bits 23..9, or bits 22..8 with the top bit ignored.
                next_op_page  = page_size_256 ? addr[flash_seq_pkg::BIN_PAGE_LSB - 8 +: 15]
                                              : addr[flash_seq_pkg::STD_PAGE_LSB - 8 +: 15];
                next_op_cnt   = 16'h0000;
                next_op_idx   = 9'h000;
                next_err      = 1'b0;
                next_state    = next_op_erase ? flash_seq_pkg::ST_ERASE
                                              : flash_seq_pkg::ST_PROG;
                next_array_req.erase = next_op_erase;
                next_array_req.page  = next_op_page;
            end
        end

        // The erase step waits out its share of the combined time.
        case (state)
            flash_seq_pkg::ST_IDLE: begin
                next_op_cnt = op_start ? 16'h0000 : op_cnt;
            end
            flash_seq_pkg::ST_ERASE: begin
                next_op_cnt = op_cnt + 16'h0001;
                if (op_cnt == ERASE_CYCLES - 16'h0001) begin
                    next_state  = flash_seq_pkg::ST_PROG;
                    next_op_cnt = 16'h0000;
                end
            end
            flash_seq_pkg::ST_PROG: begin
                // One byte per cycle, then the rest of the program time.
                next_op_cnt = op_cnt + 16'h0001;
                if (op_cnt <= {7'h00, last_loc}) begin
                    next_array_req.write     = 1'b1;
                    next_array_req.page      = op_page;
                    next_array_req.byte_addr = op_idx;
                    next_array_req.data      = buf_mem[op_sel][op_idx];
                    next_op_idx              = op_idx + 9'h001;
                end
                if (op_cnt == PROGRAM_CYCLES - 16'h0001) begin
                    next_state = flash_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = flash_seq_pkg::ST_IDLE;
            end
        endcase

        // A failure report while not idle sets the error flag and holds it to the next start.
        if (array_fail && state != flash_seq_pkg::ST_IDLE) begin
            next_err = 1'b1;
        end
        next_busy = next_state != flash_seq_pkg::ST_IDLE;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            in_frame                 <= 1'b0;
            byte_cnt                 <= 3'h0;
            addr                     <= 16'h0000;
            ptr                      <= 9'h000;
            cmd                      <= '{flash_seq_pkg::CMD_NONE, 1'b0};
            state                    <= flash_seq_pkg::ST_IDLE;
            op_sel                   <= 1'b0;
            op_erase                 <= 1'b0;
            op_page                  <= 15'h0000;
            op_idx                   <= 9'h000;
            op_cnt                   <= 16'h0000;
            array_req                <= '0;
            status_busy              <= 1'b0;
            erase_program_error_flag <= 1'b0;
        end else begin
            in_frame                 <= next_in_frame;
            byte_cnt                 <= next_byte_cnt;
            addr                     <= next_addr;
            ptr                      <= next_ptr;
            cmd                      <= next_cmd;
            state                    <= next_state;
            op_sel                   <= next_op_sel;
            op_erase                 <= next_op_erase;
            op_page                  <= next_op_page;
            op_idx                   <= next_op_idx;
            op_cnt                   <= next_op_cnt;
            array_req                <= next_array_req;
            status_busy              <= next_busy;
            erase_program_error_flag <= next_err;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_ptr_wraps: assert property (buf_we && ptr == last_loc |=> ptr == 9'h000)
        else $error("buffer pointer did not wrap to zero");
    a_ptr_steps: assert property (buf_we && ptr != last_loc && !byte_cnt[0]
                                  |=> ptr == $past(ptr) + 9'h001)
        else $error("buffer pointer did not advance");
    a_start_busy: assert property (op_start |=> status_busy [*8])
        else $error("busy not shown after program start");
    a_erase_first: assert property (op_start && next_op_erase
                                    |=> array_req.erase ##1 !array_req.write [*8])
        else $error("auto-erase program did not erase first");
    a_no_erase: assert property (status_busy && !op_erase |-> !array_req.erase)
        else $error("erase issued by a program without erase");
    a_err_sticks: assert property (array_fail && status_busy
                                   |=> erase_program_error_flag [*2])
        else $error("error flag not set by a byte failure");
    a_buf_kept: assert property (status_busy |-> !(buf_we && buf_wsel == op_sel))
        else $error("buffer under program was written");
    a_load_only: assert property (buf_we |-> cmd.kind == flash_seq_pkg::CMD_LOAD
                                  || cmd.kind == flash_seq_pkg::CMD_LOAD_PROG)
        else $error("buffer written by a non-load command");
    a_prog_end: assert property ($fell(status_busy) |-> $past(op_cnt) ==
                                 PROGRAM_CYCLES - 16'h0001)
        else $error("program step did not last its full time");
    a_page_pick: assert property (op_start && page_size_256
                                  |=> op_page == $past(addr[14:0], 1) )
        else $error("binary page field misdecoded");

endmodule : buffer_write_page_program

/* File: design/flash_seq_pkg.sv */
package flash_seq_pkg;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_LOAD_B1       = 8'h84;
    localparam logic [7:0] OP_LOAD_B2       = 8'h87;
    localparam logic [7:0] OP_PROG_ERASE_B1 = 8'h83;
    localparam logic [7:0] OP_PROG_ERASE_B2 = 8'h86;
    localparam logic [7:0] OP_PROG_PLAIN_B1 = 8'h88;
    localparam logic [7:0] OP_PROG_PLAIN_B2 = 8'h89;
    localparam logic [7:0] OP_LOAD_PROG_B1  = 8'h82;
    localparam logic [7:0] OP_LOAD_PROG_B2  = 8'h85;

    // ==========================================================
    // Address layout and buffer geometry
    localparam int         PAGE_W       = 15;
    localparam int         BADDR_W      = 9;
    localparam int         STD_PAGE_LSB = 9;
    localparam int         BIN_PAGE_LSB = 8;
    localparam int         BUF_DEPTH    = 264;
    localparam logic [8:0] LAST_STD     = 9'h107;
    localparam logic [8:0] LAST_BIN     = 9'h0ff;
    localparam logic [2:0] DATA_IDX     = 3'h4;
    localparam logic [2:0] LAST_ADDR    = 3'h3;

    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS         = 25;
    localparam int          ERASE_PROGRAM_TIME_NS = 20000;
    localparam int          PROGRAM_TIME_NS       = 10000;
    localparam logic [15:0] ERASE_CYCLES          =
        16'((ERASE_PROGRAM_TIME_NS - PROGRAM_TIME_NS) / CLK_PERIOD_NS);
    localparam logic [15:0] PROGRAM_CYCLES        = 16'(PROGRAM_TIME_NS / CLK_PERIOD_NS);

    // ==========================================================
    // Types
    typedef enum logic [2:0] {CMD_NONE, CMD_LOAD, CMD_PROG_ERASE, CMD_PROG_PLAIN,
                              CMD_LOAD_PROG} cmd_e;

    typedef struct packed {
        cmd_e kind;
        logic sel;
    } cmd_s;

    typedef struct packed {
        logic               erase;
        logic               write;
        logic [PAGE_W-1:0]  page;
        logic [BADDR_W-1:0] byte_addr;
        logic [7:0]         data;
    } array_req_s;

    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG} seq_state_e;

    // Maps an opcode to its command class and buffer select.
    function automatic cmd_s decode_op(input logic [7:0] op);
        cmd_s c;
        c.kind = CMD_NONE;
        c.sel  = 1'b0;
        case (op)
            OP_LOAD_B1:       c.kind = CMD_LOAD;
            OP_LOAD_B2:       c = '{CMD_LOAD, 1'b1};
            OP_PROG_ERASE_B1: c.kind = CMD_PROG_ERASE;
            OP_PROG_ERASE_B2: c = '{CMD_PROG_ERASE, 1'b1};
            OP_PROG_PLAIN_B1: c.kind = CMD_PROG_PLAIN;
            OP_PROG_PLAIN_B2: c = '{CMD_PROG_PLAIN, 1'b1};
            OP_LOAD_PROG_B1:  c.kind = CMD_LOAD_PROG;
            OP_LOAD_PROG_B2:  c = '{CMD_LOAD_PROG, 1'b1};
            default:          c.kind = CMD_NONE;
        endcase
        return c;
    endfunction : decode_op

endpackage : flash_seq_pkg

/* File: design/spi_byte_rx.sv */
`timescale 1ns/10ps
// ==========================================================
// Serial byte receiver on the link clock
module spi_byte_rx (
    input  wire logic       spi_sck,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_si,
    input  wire logic       sys_rst,
    output logic      [7:0] rx_byte,
    output logic            rx_toggle
);

    logic [2:0] bit_cnt;
    logic [6:0] shift;
    logic [2:0] next_bit_cnt;
    logic [6:0] next_shift;
    logic [7:0] next_rx_byte;
    logic       next_rx_toggle;

    // Bits are sampled on the rising clock edge; the eighth completes a byte.
    always_comb begin
        next_bit_cnt   = bit_cnt + 3'h1;
        next_shift     = {shift[5:0], spi_si};
        next_rx_byte   = rx_byte;
        next_rx_toggle = rx_toggle;
        if (bit_cnt == 3'h7) begin
            next_rx_byte   = {shift, spi_si};
            next_rx_toggle = ~rx_toggle;
        end
    end

    // The link clock stops between frames, so select high restarts the bit count.
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            bit_cnt <= 3'h0;
            shift   <= 7'h00;
        end else begin
            bit_cnt <= next_bit_cnt;
            shift   <= next_shift;
        end
    end

    // The toggle is never cleared by select, which would fake a byte event.
    always_ff @(posedge spi_sck or posedge sys_rst) begin
        if (sys_rst) begin
            rx_byte   <= 8'h00;
            rx_toggle <= 1'b0;
        end else begin
            rx_byte   <= next_rx_byte;
            rx_toggle <= next_rx_toggle;
        end
    end

endmodule : spi_byte_rx

/* File: dv/buffer_write_page_program_tb.sv */
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the buffer load and page program sequencer
module buffer_write_page_program_tb;
    localparam logic [15:0] E_CYC = 16'h000a;
    localparam logic [15:0] P_CYC = 16'h012c; // Must be at least 264 so a whole page fits.
    logic                      clk;
    logic                      sys_rst;
    logic                      spi_cs_n;
    logic                      spi_sck;
    logic                      spi_si;
    logic                      page_size_256;
    logic                      array_fail;
    logic                      status_busy;
    logic                      erase_program_error_flag;
    logic                      cur_sel;
    flash_seq_pkg::array_req_s array_req;
    int                        num_errors;
    int                        samples_checked;
    int                        wcnt;
    int                        ecnt;
    int                        bcnt;
    logic [7:0]                lfsr;
    logic [14:0]               exp_page;
    logic [7:0]                buf_data [2][264];
    logic                      buf_ok [2][264];
    logic [7:0]                ops [9] = '{8'h84, 8'h87, 8'h83, 8'h88, 8'h86, 8'h89,
                                           8'h82, 8'h85, 8'h81};

    buffer_write_page_program #(.ERASE_CYCLES(E_CYC), .PROGRAM_CYCLES(P_CYC)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
        .spi_si(spi_si), .page_size_256(page_size_256), .array_fail(array_fail),
        .array_req(array_req), .status_busy(status_busy),
        .erase_program_error_flag(erase_program_error_flag));
    spi_host_model i_host (.spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si));

    // ==========================================================
    // Helpers
    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr_next

    // Packs the three address bytes for either page-size layout.
    function automatic logic [23:0] addr_of(input logic ps, input logic [14:0] pg,
                                            input logic [8:0] st);
        return ps ? {1'b0, pg, st[7:0]} : {pg, st};
    endfunction : addr_of

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    // Sends one command, optionally injects an array failure, then checks the outcome.
    task automatic run_op(input logic [7:0] op, input logic ps, input logic inj);
        logic [7:0]  q[$];
        logic [23:0] a;
        logic [8:0]  last;
        logic [8:0]  ptr;
        logic        sel;
        int          kind;
        case (op)
            8'h84, 8'h87: kind = 0;
            8'h83, 8'h86: kind = 1;
            8'h88, 8'h89: kind = 2;
            8'h82, 8'h85: kind = 3;
            default:      kind = 4;
        endcase
        sel = (op == 8'h87 || op == 8'h86 || op == 8'h89 || op == 8'h85);
        last = ps ? 9'h0ff : 9'h107;
        lfsr = lfsr_next(lfsr);
        ptr = last - 9'(lfsr[1:0]); // Five bytes from here always wrap.
        if (kind != 2) exp_page = {lfsr_next(lfsr), lfsr[6:0]};
        a = addr_of(ps, exp_page, ptr);
        q = '{op, a[23:16], a[15:8], a[7:0]};
        for (int i = 0; i < 5 && (kind == 0 || kind == 3); i++) begin
            lfsr = lfsr_next(lfsr);
            q.push_back(lfsr);
            buf_data[sel][ptr] = lfsr;
            buf_ok[sel][ptr] = 1'b1;
            ptr = (ptr == last) ? 9'h000 : ptr + 9'h001;
        end
        @(posedge clk);
        page_size_256 <= ps;
        cur_sel = sel;
        wcnt = 0;
        ecnt = 0;
        bcnt = 0;
        i_host.frame(q);
        // While busy, a load or combined command into the buffer under program is refused.
        if (kind == 1 || kind == 2) begin
            q = '{(kind == 1) ? (sel ? 8'h87 : 8'h84) : (sel ? 8'h85 : 8'h82),
                  8'h00, 8'h00, 8'h00, 8'h5a, 8'ha5};
            i_host.frame(q);
        end
        if (inj) begin
            for (int i = 0; i < 50 && status_busy !== 1'b1; i++) @(posedge clk);
            repeat (5) @(posedge clk);
            array_fail <= 1'b1;
            @(posedge clk);
            array_fail <= 1'b0;
        end
        for (int i = 0; i < E_CYC + P_CYC + 100 && !(bcnt > 0 && status_busy === 1'b0); i++)
            @(posedge clk);
        check(32'(ecnt), 32'(kind == 1 || kind == 3));
        check(32'(wcnt), (kind inside {1, 2, 3}) ? (ps ? 256 : 264) : 0);
        check(32'(bcnt >= P_CYC), 32'(kind inside {1, 2, 3}));
        check(32'(erase_program_error_flag), 32'(inj));
        $display("op %h page_size_256=%0d done", op, ps);
    endtask : run_op

    // ==========================================================
    // Clock, array monitor, watchdog and main sequence
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Every array write must match the page; its data must match the buffer image wherever the loads set that byte.
    always @(posedge clk) begin
        if (sys_rst === 1'b0) begin
            if (status_busy === 1'b1) bcnt++;
            if (array_req.erase === 1'b1) ecnt++;
            if (array_req.write === 1'b1) begin
                check(32'(array_req.page), 32'(exp_page));
                check(32'(array_req.byte_addr), 32'(wcnt));
                if (buf_ok[cur_sel][array_req.byte_addr])
                    check(32'(array_req.data), 32'(buf_data[cur_sel][array_req.byte_addr]));
                wcnt++;
            end
        end
    end

    // Cuts a hang short well beyond the expected run of about eight thousand cycles.
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        // Deferred so the rising reset reaches the link-side asynchronous reset.
        sys_rst <= 1'b1;
        page_size_256 = 1'b0;
        array_fail = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        lfsr = 8'h0a;
        exp_page = 15'h0000;
        buf_ok = '{default: 1'b0};
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        check(32'(status_busy), 32'h0);
        for (int ps = 0; ps < 2; ps++) begin
            foreach (ops[i]) run_op(ops[i], ps[0], ps == 0 && i == 2);
        end
        report_and_stop();
    end
endmodule : buffer_write_page_program_tb

/* File: dv/spi_host_model.sv */
`timescale 1ns/10ps
// ==========================================================
// Host-side serial controller; its link clock runs only inside frames.
module spi_host_model (
    output logic spi_cs_n,
    output logic spi_sck,
    output logic spi_si
);
    // Idle: deselected, clock parked low for mode 0.
    // Deferred so the rising select reaches the receiver's bit-count reset at time zero.
    initial begin
        spi_cs_n <= 1'b1;
        spi_sck  <= 1'b0;
        spi_si   <= 1'b0;
    end

    // Shifts one byte MSB first on a 32 ns link clock.
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            spi_si = b[i];
            #16 spi_sck = 1'b1;
            #16 spi_sck = 1'b0;
        end
    endtask : send_byte

    // Opcode, three address bytes and data; select rises on a byte boundary.
    task automatic frame(input logic [7:0] q[$]);
        spi_cs_n = 1'b0;
        #53;
        foreach (q[i]) send_byte(q[i]);
        #170 spi_cs_n = 1'b1;
        spi_si = ~spi_si; // A released data line must not keep looking valid.
        #230;
    endtask : frame
endmodule : spi_host_model
